// ### common/gpo_pkg.sv
/*
  package for the pin output control block: register offsets, field
  layout and reset values.
  assumes an 8-bit register port with byte addresses from the host side.
*/
`default_nettype none
package gpo_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          LOW_PINS        = 6;
  localparam int          HIGH_PINS       = 5;
  localparam int          NUM_PINS        = 11;
  localparam logic [7:0]  OFS_LEVEL_LOW   = 8'h23;
  localparam logic [7:0]  OFS_LEVEL_HIGH  = 8'h24;
  localparam logic [7:0]  OFS_STYLE_LOW   = 8'h25;
  localparam logic [7:0]  OFS_STYLE_HIGH  = 8'h26;
  localparam logic [7:0]  OFS_DIR_LOW     = 8'h27;
  localparam logic [7:0]  OFS_DIR_HIGH    = 8'h28;
  localparam logic [5:0]  LOW_RESET       = 6'h00;
  localparam logic [4:0]  HIGH_RESET      = 5'h00;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
endpackage
`default_nettype wire

// ### logic/gpo_ctrl.sv
/*
  per-pin output control for an eleven-pin expander: level, drive style
  and direction registers, and the pin drivers they steer.
  assumes the serial register interface ahead of it presents one-cycle
  write and read strobes with a byte address on clock_in.
*/
// Functional notes
// - an output pin whose level bit is 0 is driven low.
// - an output pin whose level bit is 1 is set high.
// - low level register bits 5..0 are pins 6..1, bits 7..6 reserved.
// - high level register bits 4..0 are pins 11..7, bits 7..5 reserved.
// - each pin has a style bit, 0 push-pull, 1 open-drain, low bank 5..0.
// - high style register bits 4..0 are pins 11..7, bits 7..5 reserved.
// - a direction bit of 0 makes the pin an input that is never driven.
// - a direction bit of 1 makes the pin an output driven by level/style.
// - direction bits sit at 4..0 (pins 11..7) and 5..0 (pins 6..1).
// - all level, style and direction bits read back what was written.
`timescale 1ns/1ps
`default_nettype none
module gpo_ctrl (
  input  wire logic                         clock_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         wr_en_in,
  input  wire logic                         rd_en_in,
  input  wire logic [gpo_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [gpo_pkg::DATA_W-1:0]   wdata_in,
  output var  logic [gpo_pkg::DATA_W-1:0]   rdata_out,
  output var  logic                         rvalid_out,
  output var  logic [gpo_pkg::NUM_PINS-1:0] pin_out,
  output var  logic [gpo_pkg::NUM_PINS-1:0] pin_oe_out
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [5:0] level_low_r,  level_low_nxt;
  logic [4:0] level_high_r, level_high_nxt;
  logic [5:0] style_low_r,  style_low_nxt;
  logic [4:0] style_high_r, style_high_nxt;
  logic [5:0] dir_low_r,    dir_low_nxt;
  logic [4:0] dir_high_r,   dir_high_nxt;
  logic [7:0] rdata_r,      rdata_nxt;
  logic       rvalid_r,     rvalid_nxt;

  always_comb begin
    level_low_nxt  = level_low_r;
    level_high_nxt = level_high_r;
    style_low_nxt  = style_low_r;
    style_high_nxt = style_high_r;
    dir_low_nxt    = dir_low_r;
    dir_high_nxt   = dir_high_r;
    if (wr_en_in) begin
      unique case (addr_in)
        gpo_pkg::OFS_LEVEL_LOW:  level_low_nxt  = wdata_in[5:0];
        gpo_pkg::OFS_LEVEL_HIGH: level_high_nxt = wdata_in[4:0];
        gpo_pkg::OFS_STYLE_LOW:  style_low_nxt  = wdata_in[5:0];
        gpo_pkg::OFS_STYLE_HIGH: style_high_nxt = wdata_in[4:0];
        gpo_pkg::OFS_DIR_LOW:    dir_low_nxt    = wdata_in[5:0];
        gpo_pkg::OFS_DIR_HIGH:   dir_high_nxt   = wdata_in[4:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rvalid_nxt = rd_en_in;
    rdata_nxt  = rdata_r;
    if (rd_en_in) begin
      unique case (addr_in)
        gpo_pkg::OFS_LEVEL_LOW:  rdata_nxt = {2'h0, level_low_r};
        gpo_pkg::OFS_LEVEL_HIGH: rdata_nxt = {3'h0, level_high_r};
        gpo_pkg::OFS_STYLE_LOW:  rdata_nxt = {2'h0, style_low_r};
        gpo_pkg::OFS_STYLE_HIGH: rdata_nxt = {3'h0, style_high_r};
        gpo_pkg::OFS_DIR_LOW:    rdata_nxt = {2'h0, dir_low_r};
        gpo_pkg::OFS_DIR_HIGH:   rdata_nxt = {3'h0, dir_high_r};
        default:                 rdata_nxt = gpo_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      level_low_r  <= gpo_pkg::LOW_RESET;
      level_high_r <= gpo_pkg::HIGH_RESET;
      style_low_r  <= gpo_pkg::LOW_RESET;
      style_high_r <= gpo_pkg::HIGH_RESET;
      dir_low_r    <= gpo_pkg::LOW_RESET;
      dir_high_r   <= gpo_pkg::HIGH_RESET;
      rdata_r      <= 8'h00;
      rvalid_r     <= 1'b0;
    end else begin
      level_low_r  <= level_low_nxt;
      level_high_r <= level_high_nxt;
      style_low_r  <= style_low_nxt;
      style_high_r <= style_high_nxt;
      dir_low_r    <= dir_low_nxt;
      dir_high_r   <= dir_high_nxt;
      rdata_r      <= rdata_nxt;
      rvalid_r     <= rvalid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [10:0] pin_r,  pin_nxt;
  logic [10:0] oe_r,   oe_nxt;
  logic [10:0] lvl_all, sty_all, dir_all;

  assign lvl_all = {level_high_nxt, level_low_nxt};
  assign sty_all = {style_high_nxt, style_low_nxt};
  assign dir_all = {dir_high_nxt, dir_low_nxt};

  always_comb begin
    for (int i = 0; i < gpo_pkg::NUM_PINS; i++) begin
      pin_nxt[i] = lvl_all[i];
      oe_nxt[i]  = dir_all[i] & ~(sty_all[i] & lvl_all[i]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pin_r <= 11'h000;
      oe_r  <= 11'h000;
    end else begin
      pin_r <= pin_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign pin_out    = pin_r;
  assign pin_oe_out = oe_r;
  assign rdata_out  = rdata_r;
  assign rvalid_out = rvalid_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [10:0] lvl_q, sty_q, dir_q;
  assign lvl_q = {level_high_r, level_low_r};
  assign sty_q = {style_high_r, style_low_r};
  assign dir_q = {dir_high_r, dir_low_r};

  input_quiet_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    ((oe_r & ~dir_q) == 11'h000))
    else $error("input pin driven");
  drive_low_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    ((dir_q & ~lvl_q & ~(oe_r & ~pin_r)) == 11'h000))
    else $error("low output not driven");
  drive_high_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    ((dir_q & ~sty_q & lvl_q & ~(oe_r & pin_r)) == 11'h000))
    else $error("high output not driven");
  output_drive_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (oe_r == (dir_q & ~(sty_q & lvl_q))))
    else $error("output enable mismatch");
  odrain_release_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    ((oe_r & sty_q & lvl_q) == 11'h000))
    else $error("open drain drove high");
  low_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_LEVEL_LOW) |=>
    (level_low_r == $past(wdata_in[5:0])))
    else $error("low level write lost");
  high_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_LEVEL_HIGH) |=>
    (level_high_r == $past(wdata_in[4:0])))
    else $error("high level write lost");
  style_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_STYLE_LOW) |=>
    (style_low_r == $past(wdata_in[5:0])))
    else $error("style write lost");
  style_high_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_STYLE_HIGH) |=>
    (style_high_r == $past(wdata_in[4:0])))
    else $error("high style write lost");
  dir_write_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_DIR_HIGH) |=>
    (dir_high_r == $past(wdata_in[4:0])))
    else $error("direction write lost");
  dir_low_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (wr_en_in && addr_in == gpo_pkg::OFS_DIR_LOW) |=>
    (dir_low_r == $past(wdata_in[5:0])))
    else $error("low direction write lost");
  readback_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (rd_en_in && addr_in == gpo_pkg::OFS_DIR_LOW) |=>
    (rvalid_out && rdata_out == {2'h0, $past(dir_low_r)}))
    else $error("readback mismatch");
  read_pulse_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (rvalid_out == $past(rd_en_in)))
    else $error("read valid pulse wrong");
  level_hold_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    !(wr_en_in && addr_in == gpo_pkg::OFS_LEVEL_LOW) |=>
    $stable(level_low_r))
    else $error("low level changed without write");
  reserved_zero_a: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (rd_en_in && addr_in == gpo_pkg::OFS_LEVEL_HIGH) |=>
    (rdata_out[7:5] == 3'h0))
    else $error("reserved bits nonzero");

  pp_high_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    (oe_r[0] && pin_r[0]));
  pp_low_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    (oe_r[5] && !pin_r[5] && !sty_q[5]));
  od_release_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    (dir_q[10] && sty_q[10] && lvl_q[10] && !oe_r[10]));
  read_back_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    (rvalid_out && rdata_out != 8'h00));

endmodule
`default_nettype wire

// ### sim/gpo_board.sv
/*
  board model: pull-up on every expander pin, pad level from drivers.
  assumes the pin_out and pin_oe_out pair of the output block.
*/
`timescale 1ns/1ps
`default_nettype none
module gpo_board (
  input  wire logic [gpo_pkg::NUM_PINS-1:0] pin_in,
  input  wire logic [gpo_pkg::NUM_PINS-1:0] oe_in,
  output var  logic [gpo_pkg::NUM_PINS-1:0] pad_out
);
  always_comb pad_out = (pin_in & oe_in) | ~oe_in;
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/*
  self-checking bench for the pin output control block.
  assumes the board model and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wr_en_in = 1'b0;
  logic        rd_en_in = 1'b0;
  logic [7:0]  addr_in  = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic [7:0]  rdata_out;
  logic        rvalid_out;
  logic [10:0] pin_out;
  logic [10:0] pin_oe_out;
  logic [10:0] pad;
  logic [7:0]  m [0:5];
  logic [15:0] seed = 16'hFA12;
  int          err_count = 0;
  int          checked = 0;
  gpo_ctrl DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out));
  gpo_board board (.pin_in(pin_out), .oe_in(pin_oe_out), .pad_out(pad));
  initial forever #50 clock_in = ~clock_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [10:0] bank(input int i);
    return {m[i+1][4:0], m[i][5:0]};
  endfunction
  task automatic cmp_byte(input string w, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cmp_pins(input string w, input logic [10:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic check_pins;
    logic [10:0] oe;
    oe = bank(4) & ~(bank(2) & bank(0));
    cmp_pins("pin_oe_out", oe, pin_oe_out);
    cmp_pins("pad", (bank(0) & oe) | ~oe, pad);
    cmp_pins("pin_out", bank(0), pin_out);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    i = int'(a - 8'h23);
    @(posedge clock_in);
    #1;
    wr_en_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    if (i >= 0 && i < 6) m[i] = d & ((i % 2 == 0) ? 8'h3F : 8'h1F);
    @(posedge clock_in);
    #1;
    wr_en_in = 1'b0;
    check_pins();
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    logic [7:0] e;
    i = int'(a - 8'h23);
    e = (i >= 0 && i < 6) ? m[i] : gpo_pkg::READ_UNMAPPED;
    @(posedge clock_in);
    #1;
    rd_en_in = 1'b1;
    addr_in = a;
    @(posedge clock_in);
    #1;
    rd_en_in = 1'b0;
    cmp_byte("rvalid_out", 8'h01, {7'h00, rvalid_out});
    cmp_byte("rdata_out", e, rdata_out);
  endtask
  task automatic report_and_stop;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] a;
    for (int i = 0; i < 6; i++) m[i] = 8'h00;
    repeat (8) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    for (int i = 0; i < 8; i++) rd(8'h22 + i[7:0]);
    check_pins();
    wr(8'h27, 8'hFF);
    wr(8'h28, 8'hFF);
    wr(8'h23, 8'hFF);
    wr(8'h24, 8'hFF);
    wr(8'h25, 8'hFF);
    wr(8'h26, 8'hFF);
    wr(8'h29, 8'hFF);
    for (int n = 0; n < 80; n++) begin
      seed = lfsr(seed);
      a = 8'h23 + {5'h00, 3'(seed[3:0] % 7)};
      wr(a, seed[15:8]);
      rd(a);
    end
    @(posedge clock_in);
    #1;
    rst_n_in = 1'b0;
    for (int i = 0; i < 6; i++) m[i] = 8'h00;
    repeat (2) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++) rd(8'h23 + i[7:0]);
    check_pins();
    report_and_stop();
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
